// *** pkg/brk_pkg.sv ***
// Constants for the event break and trigger logic
// Contract
// - Mode one breaks execution whenever the first event trigger fires.
// - Mode two breaks execution whenever the second event trigger fires.
// - Chained arm: first trigger arms second; second re-arms first and breaks.
// - Coincidence: break via first trigger only when both comparators match together.
// - Independent: either comparator match breaks on its own trigger.
// - Freeze chain: first arms second and freezes trace; second re-arms first, breaks.
// - Continue option resumes the running program after a break.
// - Clearing the interaction mode returns to independent mode.
// - Independent break disables counter, freezes trace and raises a breakpoint.
// - Without continue, stop is default and control returns to the terminal.
`default_nettype none
package brk_pkg;
  // Interaction mode codes on the mode select input
  localparam logic [2:0] MODE_INDEPENDENT = 3'h0;
  localparam logic [2:0] MODE_SINGLE_1    = 3'h1;
  localparam logic [2:0] MODE_SINGLE_2    = 3'h2;
  localparam logic [2:0] MODE_ARM         = 3'h3;
  localparam logic [2:0] MODE_COINCIDENCE = 3'h4;
  localparam logic [2:0] MODE_FREEZE      = 3'h5;
  // Reset values
  localparam logic       ARM1_RESET       = 1'h1;
  localparam logic       ARM2_RESET       = 1'h0;
  localparam logic [2:0] MODE_RESET       = MODE_INDEPENDENT;
endpackage
`default_nettype wire

// *** design/arm_chain.sv ***
// Arming state of the two comparators for the chained modes
`default_nettype none
module arm_chain (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Control
  input  wire logic chained,
  input  wire logic hit1,
  input  wire logic hit2,
  // State
  output logic      armed1_q,
  output logic      armed2_q
);
  logic armed1_d;
  logic armed2_d;

  // Hand the arm over from one comparator to the other
  always_comb begin
    armed1_d = armed1_q;
    armed2_d = armed2_q;
    if (!chained) begin
      armed1_d = brk_pkg::ARM1_RESET;
      armed2_d = brk_pkg::ARM2_RESET;
    end else if (armed1_q && hit1) begin
      armed1_d = 1'b0;
      armed2_d = 1'b1;
    end else if (armed2_q && hit2) begin
      armed1_d = 1'b1;
      armed2_d = 1'b0;
    end
  end

  // Registered so arming counts from the next transaction
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      armed1_q <= brk_pkg::ARM1_RESET;
      armed2_q <= brk_pkg::ARM2_RESET;
    end else begin
      armed1_q <= armed1_d;
      armed2_q <= armed2_d;
    end
  end
endmodule // arm_chain
`default_nettype wire

// *** design/break_logic.sv ***
// Event break, freeze and return logic
`default_nettype none
module break_logic (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Configuration
  input  wire logic [2:0] break_interaction_mode,
  input  wire logic       clear_option,
  input  wire logic       continue_option,
  // Bus transaction qualifier and comparator matches
  input  wire logic       bus_valid,
  input  wire logic       match1,
  input  wire logic       match2,
  // Program start, restarting the counter
  input  wire logic       go_start,
  // Outputs
  output logic            first_event_trigger,
  output logic            second_event_trigger,
  output logic            break_pulse,
  output logic            resume,
  output logic            stop_to_terminal,
  output logic            trace_freeze,
  output logic            counter_enable,
  output logic [2:0]      mode_q
);
  logic [2:0] mode_d;
  logic armed1_q;
  logic armed2_q;
  logic chained;
  logic hit1;
  logic hit2;
  logic t1_d;
  logic t2_d;
  logic brk_d;
  logic frz_d;
  logic cnt_d;
  logic res_d;
  logic stp_d;

  // Mode register; clearing falls back to independent
  always_comb begin
    mode_d = break_interaction_mode;
    if (clear_option) begin
      mode_d = brk_pkg::MODE_INDEPENDENT;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= brk_pkg::MODE_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign chained = (mode_q == brk_pkg::MODE_ARM) || (mode_q == brk_pkg::MODE_FREEZE);
  assign hit1    = bus_valid && match1;
  assign hit2    = bus_valid && match2;

  arm_chain u_arm (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .chained  (chained),
    .hit1     (hit1),
    .hit2     (hit2),
    .armed1_q (armed1_q),
    .armed2_q (armed2_q)
  );

  // Trigger combination per mode
  always_comb begin
    t1_d  = 1'b0;
    t2_d  = 1'b0;
    brk_d = 1'b0;
    frz_d = trace_freeze;
    cnt_d = counter_enable;
    case (mode_q)
      brk_pkg::MODE_SINGLE_1: begin
        t1_d  = hit1;
        brk_d = hit1;
      end
      brk_pkg::MODE_SINGLE_2: begin
        t2_d  = hit2;
        brk_d = hit2;
      end
      brk_pkg::MODE_ARM: begin
        t1_d  = hit1 && armed1_q;
        t2_d  = hit2 && armed2_q;
        brk_d = t2_d;
      end
      brk_pkg::MODE_COINCIDENCE: begin
        t1_d  = hit1 && hit2;
        brk_d = t1_d;
      end
      brk_pkg::MODE_FREEZE: begin
        t1_d  = hit1 && armed1_q;
        t2_d  = hit2 && armed2_q;
        brk_d = t2_d;
        if (t1_d) begin
          frz_d = 1'b1;
        end
      end
      default: begin
        t1_d  = hit1;
        t2_d  = hit2;
        brk_d = hit1 || hit2;
      end
    endcase
    // Freeze chain already froze on the first trigger
    if (brk_d) begin
      frz_d = 1'b1;
      cnt_d = 1'b0;
    end
    // Start of a program wins: it reopens the trace and counter
    if (go_start) begin
      frz_d = 1'b0;
      cnt_d = 1'b1;
    end
  end

  // Return option after a break
  always_comb begin
    res_d = brk_d && continue_option;
    stp_d = brk_d && !continue_option;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      first_event_trigger  <= 1'b0;
      second_event_trigger <= 1'b0;
      break_pulse          <= 1'b0;
      trace_freeze         <= 1'b0;
      counter_enable       <= 1'b0;
      resume               <= 1'b0;
      stop_to_terminal     <= 1'b0;
    end else begin
      first_event_trigger  <= t1_d;
      second_event_trigger <= t2_d;
      break_pulse          <= brk_d;
      trace_freeze         <= frz_d;
      counter_enable       <= cnt_d;
      resume               <= res_d;
      stop_to_terminal     <= stp_d;
    end
  end

  // Checks beside the logic
  chk_single_one: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_SINGLE_1 && hit1) |=> break_pulse)
    else $error("single mode one missed break");
  chk_single_two: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_SINGLE_2 && !hit2) |=> !break_pulse)
    else $error("single mode two spurious break");
  chk_arm_chain: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_ARM && $past(mode_q) == brk_pkg::MODE_ARM && armed1_q && hit1) |=> armed2_q)
    else $error("first trigger did not arm second");
  chk_coin_both: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_COINCIDENCE && !(hit1 && hit2)) |=> !break_pulse)
    else $error("coincidence broke without both");
  chk_ind_either: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_INDEPENDENT && (hit1 || hit2)) |=> break_pulse && (!counter_enable || $past(go_start)))
    else $error("independent break missing");
  chk_frz_freeze: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_FREEZE && t1_d && !go_start) |=> trace_freeze)
    else $error("freeze chain did not freeze");
  chk_cont_resume: assert property (@(posedge clk_sys) disable iff (rst)
    break_pulse |-> (resume == $past(continue_option)) && (stop_to_terminal != resume))
    else $error("return option wrong");
  chk_clear_ind: assert property (@(posedge clk_sys) disable iff (rst)
    clear_option |=> mode_q == brk_pkg::MODE_INDEPENDENT)
    else $error("clear did not select independent");

  // Single modes ignore the other comparator entirely
  chk_single_ign: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_SINGLE_1) |=> !second_event_trigger)
    else $error("single mode one raised second trigger");

  chk_single2_ign: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_SINGLE_2) |=> !first_event_trigger)
    else $error("single mode two raised first trigger");

  // Armed second comparator breaks; unarmed one is refused
  chk_arm_break: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_ARM && armed2_q && hit2) |=> break_pulse && second_event_trigger)
    else $error("armed second trigger did not break");

  chk_arm_refuse: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_ARM && !armed2_q) |=> !break_pulse)
    else $error("chained arm broke while unarmed");

  // Coincidence fires only through the first trigger
  chk_coin_fire: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_COINCIDENCE && hit1 && hit2) |=> first_event_trigger && break_pulse
      && !second_event_trigger)
    else $error("coincidence did not break on both");

  chk_ind_second: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_INDEPENDENT && hit2) |=> second_event_trigger)
    else $error("independent second trigger missing");

  // Freeze chain re-arms the first comparator when it breaks
  chk_frz_rearm: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_FREEZE && armed2_q && hit2) |=> armed1_q && break_pulse)
    else $error("freeze chain did not re-arm first");

  chk_frz_nobrk: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == brk_pkg::MODE_FREEZE && !(armed2_q && hit2)) |=> !break_pulse)
    else $error("freeze chain broke without second trigger");

  // Freeze is sticky until the next program start
  chk_freeze_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (trace_freeze && !go_start) |=> trace_freeze)
    else $error("trace freeze released early");

  chk_stop_default: assert property (@(posedge clk_sys) disable iff (rst)
    break_pulse |-> (stop_to_terminal == !$past(continue_option)))
    else $error("stop option wrong after break");

  // A break shuts the counter and freezes the trace
  chk_brk_freeze: assert property (@(posedge clk_sys) disable iff (rst)
    (break_pulse && !$past(go_start)) |-> trace_freeze && !counter_enable)
    else $error("break left trace or counter running");

  chk_go_reopen: assert property (@(posedge clk_sys) disable iff (rst)
    go_start |=> !trace_freeze && counter_enable)
    else $error("program start did not reopen trace");

  // Outside chained modes the arm rests on the first comparator
  chk_arm_unchain: assert property (@(posedge clk_sys) disable iff (rst)
    !chained |=> armed1_q && !armed2_q)
    else $error("arm state not reset outside chained modes");
endmodule // break_logic
`default_nettype wire

// *** sim/emu_bus_model.sv ***
// Emulator-side model: bus transactions with inserted wait states
`default_nettype none
module emu_bus_model #(
  parameter int WAITS = 1
) (
  // Clock
  input  wire logic clk_sys,
  // Transaction qualifier and comparator matches
  output logic      bus_valid,
  output logic      match1,
  output logic      match2
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    bus_valid = 1'h0;
    match1    = 1'h0;
    match2    = 1'h0;
  end
  // One transaction; caller sits on a falling edge; no I/O qualifiers selected
  task automatic xfer(input logic m1, input logic m2);
    // Wait states show as idle cycles ahead of the transaction
    repeat (WAITS) begin
      match1 = ~match1; // Unqualified lines never hold a stale value
      match2 = ~match2;
      @(negedge clk_sys);
    end
    bus_valid = 1'h1;
    match1    = m1;
    match2    = m2;
    @(negedge clk_sys);
    bus_valid = 1'h0;
    match1    = ~m1;
    match2    = ~m2;
  endtask
endmodule // emu_bus_model
`default_nettype wire

// *** sim/break_logic_bench.sv ***
// Self-checking bench for the event break and trigger logic
`default_nettype none
module break_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 1'h0;
  logic       rst, clear_option, continue_option, go_start;
  logic [2:0] break_interaction_mode, mode_q;
  logic       bus_valid, match1, match2;
  logic       first_event_trigger, second_event_trigger, break_pulse, resume;
  logic       stop_to_terminal, trace_freeze, counter_enable;
  int         num_errors = 0;
  int         total_checks = 0;
  int         cyc = 0;
  break_logic dut (.clk_sys, .rst, .break_interaction_mode, .clear_option, .continue_option, .bus_valid,
                   .match1, .match2, .go_start, .first_event_trigger, .second_event_trigger, .break_pulse,
                   .resume, .stop_to_terminal, .trace_freeze, .counter_enable, .mode_q);
  emu_bus_model #(.WAITS(1)) emu (.clk_sys, .bus_valid, .match1, .match2);
  // 100 MHz clock, the emulator clock as already delivered to the analyzer
  always #5 clk_sys = ~clk_sys;
  // Hang guard, far above the 44 or so cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 2000) begin
      num_errors++;
      results();
    end
  end
  // Outputs packed as trig1, trig2, break, resume, stop, freeze, count enable
  function automatic logic [6:0] o();
    return {first_event_trigger, second_event_trigger, break_pulse, resume, stop_to_terminal, trace_freeze,
            counter_enable};
  endfunction
  task automatic chk(input string nm, input logic [6:0] seen, input logic [6:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Mode and return option with a program start; go also unfreezes the trace
  task automatic setup(input logic [2:0] m, input logic c);
    break_interaction_mode = m;
    continue_option = c;
    go_start = 1'h1;
    @(negedge clk_sys);
    go_start = 1'h0;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1'h1;
    clear_option = 1'h0;
    continue_option = 1'h0;
    go_start = 1'h0;
    break_interaction_mode = brk_pkg::MODE_ARM;
    repeat (6) @(negedge clk_sys);
    rst = 1'h0;
    chk("reset outputs", o(), 7'h00);
    chk("reset mode", {4'h0, mode_q}, 7'h00);
    setup(brk_pkg::MODE_INDEPENDENT, 1'h0);
    emu.xfer(1'h1, 1'h0);
    chk("indep first_event_trigger stop", o(), 7'h56);
    setup(brk_pkg::MODE_INDEPENDENT, 1'h1);
    emu.xfer(1'h0, 1'h1);
    chk("indep second_event_trigger cont", o(), 7'h3A);
    setup(brk_pkg::MODE_SINGLE_1, 1'h0);
    emu.xfer(1'h0, 1'h1);
    chk("single1 second_event_trigger", o(), 7'h01);
    emu.xfer(1'h1, 1'h0);
    chk("single1 first_event_trigger", o(), 7'h56);
    setup(brk_pkg::MODE_SINGLE_2, 1'h0);
    emu.xfer(1'h1, 1'h0);
    chk("single2 first_event_trigger", o(), 7'h01);
    emu.xfer(1'h0, 1'h1);
    chk("single2 second_event_trigger", o(), 7'h36);
    setup(brk_pkg::MODE_ARM, 1'h1);
    emu.xfer(1'h0, 1'h1);
    chk("arm unarmed second_event_trigger", o(), 7'h01);
    emu.xfer(1'h1, 1'h0);
    chk("arm first_event_trigger", {4'h0, o()[6:4]}, 7'h04);
    emu.xfer(1'h1, 1'h0);
    chk("arm first_event_trigger again", {4'h0, o()[6:4]}, 7'h00);
    emu.xfer(1'h0, 1'h1);
    chk("arm second_event_trigger", o(), 7'h3A);
    setup(brk_pkg::MODE_FREEZE, 1'h0);
    emu.xfer(1'h1, 1'h0);
    chk("freeze first_event_trigger", {3'h0, o()[6:4], trace_freeze}, 7'h09);
    emu.xfer(1'h0, 1'h1);
    chk("freeze second_event_trigger", {4'h0, o()[5:3]}, 7'h06);
    setup(brk_pkg::MODE_COINCIDENCE, 1'h0);
    emu.xfer(1'h1, 1'h0);
    chk("coinc first_event_trigger only", o(), 7'h01);
    emu.xfer(1'h0, 1'h1);
    chk("coinc second_event_trigger only", o(), 7'h01);
    emu.xfer(1'h1, 1'h1);
    chk("coinc both", {1'h0, o()[6], o()[4:0]}, 7'h36);
    // Clear must beat a chained mode on the mode input
    break_interaction_mode = brk_pkg::MODE_ARM;
    clear_option = 1'h1;
    @(negedge clk_sys);
    chk("clear mode", {4'h0, mode_q}, 7'h00);
    results();
  end
endmodule // break_logic_bench
`default_nettype wire
